// file: rtl/sebfe_pkg.sv
// Package of constants and types for the serial EEPROM bus front end.
package sebfe_pkg;
  localparam logic [3:0] DEV_TYPE_PREFIX = 4'hA;
  localparam int WORD_BITS = 8;
  localparam int RECOVERY_CLOCKS = 9;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_CYCLE_TIME_MS = 10;
  localparam int WRITE_CYCLE_CLKS = (WRITE_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [1:0] VARIANT_2K = 2'h0;
  localparam logic [1:0] VARIANT_4K = 2'h1;
  localparam logic [1:0] VARIANT_8K = 2'h2;
  localparam logic [1:0] VARIANT_16K = 2'h3;
  localparam logic [1:0] VARIANT_RESET = 2'h0;

  typedef struct packed {
    logic match;
    logic [2:0] page;
    logic readNotWrite;
  } sebfe_addr_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
  } sebfe_bus_ev_t;
endpackage : sebfe_pkg

// file: rtl/sebfe_line_sync.sv
// Two-stage synchroniser and edge/condition detector for the SCL and SDA pins.
`timescale 1ns/10ps
`default_nettype none
module sebfe_line_sync
(
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output wire sebfe_pkg::sebfe_bus_ev_t busEv
);
  logic [1:0] sclMeta_reg;
  logic [1:0] sdaMeta_reg;
  logic sclOld_reg;
  logic sdaOld_reg;
  wire logic sclNow;
  wire logic sdaNow;

  assign sclNow = sclMeta_reg[1];
  assign sdaNow = sdaMeta_reg[1];

  // Idle bus level is high, so the history starts high to avoid a false condition after reset.
  always_ff @(posedge sysClk)
  begin
    if (!rstn)
    begin
      sclMeta_reg <= 2'h3;
      sdaMeta_reg <= 2'h3;
      sclOld_reg <= 1'b1;
      sdaOld_reg <= 1'b1;
    end
    else if (clkEn)
    begin
      sclMeta_reg <= {sclMeta_reg[0], sclIn};
      sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
      sclOld_reg <= sclNow;
      sdaOld_reg <= sdaNow;
    end
  end

  assign busEv.start = clkEn && sclNow && sclOld_reg && sdaOld_reg && !sdaNow;
  assign busEv.stop = clkEn && sclNow && sclOld_reg && !sdaOld_reg && sdaNow;
  assign busEv.sclRise = clkEn && sclNow && !sclOld_reg;
  assign busEv.sclFall = clkEn && !sclNow && sclOld_reg;
  assign busEv.sdaLevel = sdaNow;
endmodule : sebfe_line_sync
`default_nettype wire

// file: rtl/sebfe_front_end.sv
// Bus front end of a two-wire serial EEPROM: framing, acknowledge, address decode, busy time.
`timescale 1ns/10ps
`default_nettype none
module sebfe_front_end
#(
  parameter int WRITE_CYCLE_CLKS = sebfe_pkg::WRITE_CYCLE_CLKS,
  parameter logic [1:0] VARIANT = sebfe_pkg::VARIANT_2K
)
(
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrStrapHigh,
  input wire logic addrStrapMid,
  input wire logic addrStrapLow,
  output logic standby,
  output logic selected,
  output logic readMode,
  output logic [2:0] pageBits,
  output logic [7:0] rxWord,
  output logic rxWordValid,
  output logic writeBusy,
  output logic [3:0] wordAddrBits
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_IGNORE, ST_BUSY} sebfe_state_t;

  sebfe_pkg::sebfe_bus_ev_t busEv;
  sebfe_state_t state_reg;
  sebfe_state_t state_next;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic ackDrive_reg;
  logic selected_reg;
  logic readMode_reg;
  logic wrote_reg;
  logic [2:0] page_reg;
  logic [7:0] rxWord_reg;
  logic rxValid_reg;
  logic [31:0] busyCnt_reg;
  logic [2:0] strapSync1_reg;
  logic [2:0] strapSync2_reg;

  sebfe_line_sync u_line_sync
  (
    .sysClk(sysClk),
    .rstn(rstn),
    .clkEn(clkEn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .busEv(busEv)
  );

  // Decodes a device address word against the straps for the configured capacity.
  function automatic sebfe_pkg::sebfe_addr_t decodeAddr(input logic [7:0] w, input logic [2:0] straps);
    sebfe_pkg::sebfe_addr_t d;
    d.readNotWrite = w[0];
    d.page = 3'h0;
    d.match = (w[7:4] == sebfe_pkg::DEV_TYPE_PREFIX);
    unique case (VARIANT)
      sebfe_pkg::VARIANT_2K: d.match = d.match && (w[3:1] == straps);
      sebfe_pkg::VARIANT_4K:
      begin
        d.match = d.match && (w[3:2] == straps[2:1]);
        d.page = {2'h0, w[1]};
      end
      sebfe_pkg::VARIANT_8K:
      begin
        d.match = d.match && (w[3] == straps[2]);
        d.page = {1'b0, w[2:1]};
      end
      sebfe_pkg::VARIANT_16K: d.page = w[3:1];
    endcase
    return d;
  endfunction : decodeAddr

  wire logic [2:0] strapLevels = strapSync2_reg;
  wire logic [7:0] fullWord = {shift_reg[6:0], busEv.sdaLevel};
  wire sebfe_pkg::sebfe_addr_t addrDec = decodeAddr(fullWord, strapLevels);
  wire logic lastBitRise = busEv.sclRise && (bitCnt_reg == 4'(sebfe_pkg::WORD_BITS - 1));
  wire logic busyDone = (busyCnt_reg >= 32'(WRITE_CYCLE_CLKS - 1));

  // Straps are static board levels but still pass two flip-flops as they come from pins.
  always_ff @(posedge sysClk)
  begin
    if (!rstn)
    begin
      strapSync1_reg <= 3'h0;
      strapSync2_reg <= 3'h0;
    end
    else if (clkEn)
    begin
      strapSync1_reg <= {addrStrapHigh, addrStrapMid, addrStrapLow};
      strapSync2_reg <= strapSync1_reg;
    end
  end

  // The write busy time ignores the bus entirely, so polling is not acknowledged until it ends.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (busEv.start) state_next = ST_ADDR;
      ST_ADDR:
      begin
        if (busEv.stop) state_next = ST_IDLE;
        else if (busEv.start) state_next = ST_ADDR;
        else if (lastBitRise) state_next = addrDec.match ? ST_ACK : ST_IGNORE;
      end
      ST_ACK:
      begin
        if (busEv.stop) state_next = (wrote_reg && !readMode_reg) ? ST_BUSY : ST_IDLE;
        else if (busEv.start) state_next = ST_ADDR;
        // The first falling edge opens the acknowledge; the second one closes the ninth clock.
        else if (busEv.sclFall && ackDrive_reg) state_next = ST_DATA;
      end
      ST_DATA:
      begin
        if (busEv.stop) state_next = (wrote_reg && !readMode_reg) ? ST_BUSY : ST_IDLE;
        else if (busEv.start) state_next = ST_ADDR;
        else if (lastBitRise && !readMode_reg) state_next = ST_ACK;
      end
      ST_IGNORE:
      begin
        if (busEv.start) state_next = ST_ADDR;
        else if (busEv.stop) state_next = ST_IDLE;
      end
      ST_BUSY: if (busyDone) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sysClk)
  begin
    if (!rstn)
      state_reg <= ST_IDLE;
    else if (clkEn)
      state_reg <= state_next;
  end

  // Bit counter and shifter; a start or stop restarts the word regardless of position.
  always_ff @(posedge sysClk)
  begin
    if (!rstn)
    begin
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (clkEn)
    begin
      if (busEv.start || busEv.stop || state_next == ST_ACK)
        bitCnt_reg <= 4'h0;
      else if (busEv.sclRise && (state_reg == ST_ADDR || state_reg == ST_DATA))
      begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
        shift_reg <= fullWord;
      end
    end
  end

  always_ff @(posedge sysClk)
  begin
    if (!rstn)
    begin
      selected_reg <= 1'b0;
      readMode_reg <= 1'b0;
      page_reg <= 3'h0;
      wrote_reg <= 1'b0;
      rxWord_reg <= 8'h00;
      rxValid_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      rxValid_reg <= 1'b0;
      if (state_reg == ST_ADDR && lastBitRise && !busEv.start && !busEv.stop)
      begin
        selected_reg <= addrDec.match;
        readMode_reg <= addrDec.readNotWrite;
        page_reg <= addrDec.page;
        wrote_reg <= addrDec.match && !addrDec.readNotWrite;
      end
      else if (state_reg == ST_DATA && lastBitRise && !readMode_reg)
      begin
        rxWord_reg <= fullWord;
        rxValid_reg <= 1'b1;
      end
      else if (state_next == ST_IDLE || state_next == ST_BUSY)
        selected_reg <= 1'b0;
    end
  end

  // Acknowledge is raised after the eighth rising edge and held through the ninth clock.
  always_ff @(posedge sysClk)
  begin
    if (!rstn)
      ackDrive_reg <= 1'b0;
    else if (clkEn)
    begin
      if (busEv.start || busEv.stop)
        ackDrive_reg <= 1'b0;
      else if (state_reg == ST_ACK && busEv.sclFall)
        ackDrive_reg <= !ackDrive_reg;
      else if (state_reg != ST_ACK)
        ackDrive_reg <= 1'b0;
    end
  end

  always_ff @(posedge sysClk)
  begin
    if (!rstn)
      busyCnt_reg <= 32'h0;
    else if (clkEn)
      busyCnt_reg <= (state_reg == ST_BUSY) ? busyCnt_reg + 32'h1 : 32'h0;
  end

  // Open-drain data pin: only ever pulled low.
  assign sdaOut = 1'b0;
  assign sdaOe = ackDrive_reg;
  assign standby = (state_reg == ST_IDLE) || (state_reg == ST_IGNORE);
  assign selected = selected_reg;
  assign readMode = readMode_reg;
  assign pageBits = page_reg;
  assign rxWord = rxWord_reg;
  assign rxWordValid = rxValid_reg;
  assign writeBusy = (state_reg == ST_BUSY);
  assign wordAddrBits = 4'(8 + int'(VARIANT));
endmodule : sebfe_front_end
`default_nettype wire

// file: sim/sebfe_front_end_monitor.sv
// Port checker for the serial EEPROM bus front end.
`timescale 1ns/10ps
`default_nettype none
module sebfe_front_end_monitor
#(
  parameter int WRITE_CYCLE_CLKS = 100,
  parameter logic [1:0] VARIANT = 2'h0
)
(
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic standby,
  input wire logic selected,
  input wire logic readMode,
  input wire logic rxWordValid,
  input wire logic writeBusy,
  input wire logic [3:0] wordAddrBits
);
  int busyCnt_reg;
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!rstn);
  // The busy time is far too long for a repetition, so its enabled cycles are counted here.
  always_ff @(posedge sysClk)
  begin
    if (!rstn || !writeBusy)
      busyCnt_reg <= 0;
    else if (clkEn)
      busyCnt_reg <= busyCnt_reg + 1;
  end
  sequence ackSoon;
    ##[1:12] sdaOe;
  endsequence
  sequence ackHeld;
    sdaOe [*4];
  endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0) !rstn && clkEn |=> standby && !sdaOe)
    else $error("not idle after reset");
  AST_ACK_AFTER_WORD: assert property (rxWordValid |-> ackSoon)
    else $error("no ack after word");
  AST_ACK_HELD: assert property ($rose(sdaOe) |-> ackHeld)
    else $error("ack too short");
  AST_PULL_LOW: assert property (sdaOe |-> !sdaOut)
    else $error("ack not low");
  AST_NO_ACK_IDLE: assert property (sdaOe |-> !standby && !writeBusy)
    else $error("ack while idle");
  AST_SEL_ACTIVE: assert property (selected |-> !standby)
    else $error("selected in standby");
  AST_WORD_PULSE: assert property (rxWordValid |=> !rxWordValid)
    else $error("word pulse long");
  AST_WRITE_DATA: assert property (rxWordValid |-> selected && !readMode)
    else $error("word outside write");
  AST_BUSY_BOUND: assert property (writeBusy |-> busyCnt_reg < WRITE_CYCLE_CLKS)
    else $error("busy too long");
  AST_BUSY_END: assert property ($fell(writeBusy) |-> ##[0:2] standby)
    else $error("no standby after write");
  AST_ADDR_WIDTH: assert property (wordAddrBits == 4'h8 + {2'h0, VARIANT})
    else $error("word address width");
endmodule : sebfe_front_end_monitor
bind sebfe_front_end sebfe_front_end_monitor #(.WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS), .VARIANT(VARIANT)) i_mon (
  .sysClk(sysClk), .rstn(rstn), .clkEn(clkEn), .sdaOut(sdaOut), .sdaOe(sdaOe), .standby(standby),
  .selected(selected), .readMode(readMode), .rxWordValid(rxWordValid), .writeBusy(writeBusy),
  .wordAddrBits(wordAddrBits)
);
`default_nettype wire

// file: sim/sebfe_bus_ctrl.sv
// Behavioural two-wire bus controller driving SCL and pulling SDA.
`timescale 1ns/10ps
`default_nettype none
module sebfe_bus_ctrl
(
  input wire logic sysClk,
  output logic sclOut,
  output logic sdaPull,
  input wire logic sdaWire
);
  initial
  begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // An eight-cycle bit slot; SDA moves two cycles into the low phase and SCL stands high between frames.
  task automatic bit_io(input logic b, output logic seen);
    repeat (2) @(posedge sysClk);
    sdaPull <= !b;
    repeat (2) @(posedge sysClk);
    sclOut <= 1'b1;
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    seen = sdaWire;
    repeat (2) @(posedge sysClk);
    sclOut <= 1'b0;
  endtask : bit_io
  task automatic start_cond();
    repeat (2) @(posedge sysClk);
    sdaPull <= 1'b0;
    repeat (2) @(posedge sysClk);
    sclOut <= 1'b1;
    repeat (4) @(posedge sysClk);
    sdaPull <= 1'b1;
    repeat (4) @(posedge sysClk);
    sclOut <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    repeat (2) @(posedge sysClk);
    sdaPull <= 1'b1;
    repeat (2) @(posedge sysClk);
    sclOut <= 1'b1;
    repeat (4) @(posedge sysClk);
    sdaPull <= 1'b0;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(b[i], seen);
    end
    bit_io(1'b1, seen);
    ack = !seen;
  endtask : send_byte
  task automatic recover();
    logic seen;
    for (int i = 0; i < 9; i++)
    begin
      bit_io(1'b1, seen);
    end
  endtask : recover
endmodule : sebfe_bus_ctrl
`default_nettype wire

// file: sim/testbench.sv
// Self-checking testbench for the serial EEPROM bus front end.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int BUSY_CLKS = 400;
  logic sysClk, rstn, clkEn, sclIn, sdaPull, sdaOut, sdaOe, standby, selected, readMode, rxWordValid, writeBusy, ack;
  logic [2:0] pageBits, straps;
  logic [3:0] wordAddrBits;
  logic [7:0] rxWord, data, a;
  logic [31:0] seed;
  int error_cnt, comparisons, n, busyLen;
  wire logic sdaWire = !(sdaPull | (sdaOe & !sdaOut));
  sebfe_bus_ctrl i_sebfe_bus_ctrl (.sysClk(sysClk), .sclOut(sclIn), .sdaPull(sdaPull), .sdaWire(sdaWire));
  sebfe_front_end #(.WRITE_CYCLE_CLKS(BUSY_CLKS), .VARIANT(sebfe_pkg::VARIANT_2K)) i_sebfe_front_end (
    .sysClk(sysClk), .rstn(rstn), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrStrapHigh(straps[2]), .addrStrapMid(straps[1]), .addrStrapLow(straps[0]), .standby(standby),
    .selected(selected), .readMode(readMode), .pageBits(pageBits), .rxWord(rxWord), .rxWordValid(rxWordValid),
    .writeBusy(writeBusy), .wordAddrBits(wordAddrBits)
  );
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic exp_ack(input logic [7:0] w);
    return w[7:4] == 4'hA && w[3:1] == straps;
  endfunction : exp_ack
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic addr_word(input logic [7:0] w, input logic busy);
    i_sebfe_bus_ctrl.start_cond();
    i_sebfe_bus_ctrl.send_byte(w, ack);
    @(negedge sysClk);
    check("addr ack", {7'h00, exp_ack(w) && !busy}, {7'h00, ack});
  endtask : addr_word
  task automatic report_and_stop();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    sysClk = 1'b0;
    forever #50 sysClk = !sysClk;
  end
  // Busy time is counted over enabled cycles only, so a freeze has to stretch it.
  always @(negedge sysClk)
  begin
    if (writeBusy === 1'b1 && clkEn === 1'b1)
      busyLen++;
  end
  initial
  begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    rstn = 1'b0;
    clkEn = 1'b1;
    seed = xorshift(32'h00000021);
    straps = seed[2:0];
    seed = xorshift(seed);
    data = seed[7:0];
    repeat (4) @(posedge sysClk);
    rstn <= 1'b1;
    repeat (4) @(negedge sysClk);
    check("standby", 8'h01, {7'h00, standby});
    check("addr width", 8'h08, {4'h0, wordAddrBits});
    i_sebfe_bus_ctrl.recover();
    addr_word({4'hA, straps, 1'b0}, 1'b0);
    check("status", 8'h04, {2'h0, pageBits, selected, readMode, standby});
    i_sebfe_bus_ctrl.send_byte(data, ack);
    @(negedge sysClk);
    check("data ack", 8'h01, {7'h00, ack});
    check("rx word", data, rxWord);
    i_sebfe_bus_ctrl.stop_cond();
    repeat (10) @(negedge sysClk);
    check("busy", 8'h01, {7'h00, writeBusy});
    @(posedge sysClk);
    clkEn <= 1'b0;
    repeat (10) @(posedge sysClk);
    clkEn <= 1'b1;
    addr_word({4'hA, straps, 1'b0}, 1'b1);
    i_sebfe_bus_ctrl.stop_cond();
    n = 0;
    while (writeBusy !== 1'b0 && n < 1000)
    begin
      @(negedge sysClk);
      n++;
    end
    check("busy end", 8'h03, {6'h00, standby, n < BUSY_CLKS});
    check("busy length", 8'h01, {7'h00, busyLen == BUSY_CLKS});
    $display("Test write done");
    addr_word({4'hA, ~straps, 1'b0}, 1'b0);
    check("standby", 8'h01, {7'h00, standby});
    i_sebfe_bus_ctrl.send_byte(data, ack);
    check("ignored ack", 8'h00, {7'h00, ack});
    i_sebfe_bus_ctrl.stop_cond();
    $display("Test mismatch done");
    for (int k = 0; k < 8; k++)
    begin
      seed = xorshift(seed);
      a = (k == 0) ? {4'hA, straps, 1'b1} : (k == 1) ? {4'h2, straps, 1'b1} : {seed[7:1], 1'b1};
      addr_word(a, 1'b0);
      if (exp_ack(a))
      begin
        check("read mode", 8'h01, {7'h00, readMode});
      end
      i_sebfe_bus_ctrl.stop_cond();
      repeat (6) @(negedge sysClk);
      check("read stop", 8'h02, {6'h00, standby, writeBusy});
    end
    $display("Test read done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
